// *** inc/flash_flags_pkg.sv ***
// Purpose: constants and types for the flash sequence flag unit
// Assumes: 40 MHz system clock, 16-bit cpu address offset inside the bank
// Notes: command codes sit in the low data byte, the upper byte is ignored
//
// Behaviour
// - protection query answers 01 protected, 00 not
// - both reset command forms return to read
// - flags sit at bits 7,6,5,3,2
// - algorithm end returns to read mode
// - programming polls inverse of written bit 7
// - finished program reads true bit 7
// - erase polls 0 in sector, then 1
// - suspended erase sector polls 1
// - reads ignored while algorithm starts
// - suspend, other sector returns true data
// - failure: limit 1, flags per kind
// - second toggle only in busy sector
// - flags show further sector codes accepted
// - toggle flag alternates each busy read outside suspend
// - finished algorithm reads true bit 6
// - limit flag 0 in time, 1 over
package flash_flags_pkg;
    localparam logic [15:0] CMD_ADDR_A   = 16'hAAAA;
    localparam logic [15:0] CMD_ADDR_5   = 16'h5554;
    localparam logic [7:0]  CODE_AA      = 8'hAA;
    localparam logic [7:0]  CODE_55      = 8'h55;
    localparam logic [7:0]  CODE_RESET   = 8'hF0;
    localparam logic [7:0]  CODE_PROG    = 8'hA0;
    localparam logic [7:0]  CODE_ERASE   = 8'h80;
    localparam logic [7:0]  CODE_CHIP    = 8'h10;
    localparam logic [7:0]  CODE_SECTOR  = 8'h30;
    localparam logic [7:0]  CODE_SUSPEND = 8'hB0;
    localparam logic [7:0]  CODE_AUTOSEL = 8'h90;
    localparam logic [7:0]  PROT_YES     = 8'h01;
    localparam logic [7:0]  PROT_NO      = 8'h00;
    localparam logic [7:0]  AS_MASK      = 8'h87;
    localparam logic [7:0]  AS_MATCH     = 8'h04;
    localparam int          SECT_HI      = 15;
    localparam int          SECT_LO      = 13;
    localparam int          SECT_N       = 8;
    localparam int          POS_POLL     = 7;
    localparam int          POS_TOGGLE   = 6;
    localparam int          POS_LIMIT    = 5;
    localparam int          POS_WINDOW   = 3;
    localparam int          POS_TOGGLE2  = 2;
    localparam int          CLK_PERIOD_NS   = 25;
    localparam int          START_IGNORE_NS = 25;
    localparam int          START_IGNORE_CYC =
        (START_IGNORE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0]  RESET_BYTE   = 8'h00;
    localparam logic [15:0] RESET_WORD   = 16'h0000;

    typedef enum logic [2:0] {
        MODE_READ, MODE_AUTOSEL, MODE_PROG,
        MODE_ERASE_WAIT, MODE_ERASE, MODE_SUSPEND
    } mode_t;

    typedef enum logic [2:0] {
        CY_IDLE, CY_UNLOCK1, CY_UNLOCK2, CY_PROG_DATA,
        CY_ERASE1, CY_ERASE2, CY_ERASE3
    } cyc_t;
endpackage : flash_flags_pkg

// *** inc/flag_state_if.sv ***
// Purpose: carries algorithm state to the status byte former
// Assumes: single clock domain, all fields but read_byte and is_status driven by the top
// Notes: read_byte and is_status come back from the former
`timescale 1ns/10ps
interface flag_state_if;
    import flash_flags_pkg::*;
    mode_t       mode;
    logic        in_sector;
    logic        toggle;
    logic        toggle2;
    logic        time_over;
    logic        last_bit7;
    logic        sect_prot;
    logic        autosel_hit;
    logic [7:0]  array_byte;
    logic [7:0]  read_byte;
    logic        is_status;

    modport source (output mode, in_sector, toggle, toggle2, time_over,
                    last_bit7, sect_prot, autosel_hit, array_byte,
                    input read_byte, is_status);
    modport former (input mode, in_sector, toggle, toggle2, time_over,
                    last_bit7, sect_prot, autosel_hit, array_byte,
                    output read_byte, is_status);
endinterface : flag_state_if

// *** rtl/flag_byte_former.sv ***
// Purpose: forms the byte a read returns in each algorithm mode
// Assumes: inputs come from the top module, some from its flops, the rest from its ports and address decode
// Notes: purely combinational, the top registers the result
`timescale 1ns/10ps
module flag_byte_former (
    flag_state_if.former st
);
    import flash_flags_pkg::*;
    logic [7:0] b;
    logic       stat;

    always_comb begin
        b    = RESET_BYTE;
        stat = 1'b0;
        case (st.mode)
            MODE_AUTOSEL: begin
                if (st.autosel_hit) begin
                    b = st.sect_prot ? PROT_YES : PROT_NO;
                end else begin
                    b = st.array_byte;
                end
            end
            MODE_PROG: begin
                stat            = 1'b1;
                b[POS_POLL]     = ~st.last_bit7;
                b[POS_TOGGLE]   = st.toggle;
                b[POS_LIMIT]    = st.time_over;
                b[POS_WINDOW]   = 1'b0;
                b[POS_TOGGLE2]  = 1'b1;
            end
            MODE_ERASE_WAIT: begin
                stat            = 1'b1;
                b[POS_POLL]     = 1'b0;
                b[POS_TOGGLE]   = st.toggle;
                b[POS_LIMIT]    = st.time_over;
                b[POS_WINDOW]   = 1'b0;
                b[POS_TOGGLE2]  = st.toggle2;
            end
            MODE_ERASE: begin
                stat            = 1'b1;
                b[POS_POLL]     = 1'b0;
                b[POS_TOGGLE]   = st.toggle;
                b[POS_LIMIT]    = st.time_over;
                b[POS_WINDOW]   = 1'b1;
                b[POS_TOGGLE2]  = st.toggle2;
            end
            MODE_SUSPEND: begin
                if (st.in_sector) begin
                    stat           = 1'b1;
                    b[POS_POLL]    = 1'b1;
                    b[POS_TOGGLE]  = 1'b1;
                    b[POS_LIMIT]   = 1'b0;
                    b[POS_WINDOW]  = 1'b0;
                    b[POS_TOGGLE2] = st.toggle2;
                end else begin
                    b = st.array_byte;
                end
            end
            default: begin
                b = st.array_byte;
            end
        endcase
    end

    assign st.read_byte = b;
    assign st.is_status = stat;
endmodule : flag_byte_former

// *** rtl/flash_algorithm_status_flags.sv ***
// Purpose: command decode and sequence flag reads of the flash bank
// Assumes: strobes and array data come from logic on SYS_CLK
// Notes: the array sequencer does the real timing, this unit reports it
`timescale 1ns/10ps
module flash_algorithm_status_flags (
    input  wire logic        SYS_CLK,
    input  wire logic        RESETN,
    input  wire logic        CLK_EN,
    input  wire logic        WR_STB,
    input  wire logic        RD_STB,
    input  wire logic [15:0] ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic [15:0] ARRAY_DATA,
    input  wire logic        SECT_PROTECTED,
    input  wire logic        SEQ_DONE,
    input  wire logic        SEQ_TIME_OVER,
    input  wire logic        SEQ_ERASE_BEGIN,
    output logic      [7:0]  RDATA,
    output logic             RDATA_VALID,
    output logic             PROG_START,
    output logic      [15:0] PROG_LOCATION,
    output logic      [15:0] PROG_VALUE,
    output logic             CHIP_ERASE_START,
    output logic             SECTOR_ERASE_START,
    output logic      [7:0]  ERASE_SECTORS,
    output logic             ERASE_SUSPEND,
    output logic             ALG_ABORT,
    output logic             ALG_BUSY
);
    import flash_flags_pkg::*;

    mode_t       mode_q, mode_d;
    cyc_t        cyc_q, cyc_d;
    logic [7:0]  mask_q, mask_d;
    logic        toggle_q, toggle2_q, last_bit7_q;
    logic [1:0]  start_q;
    logic [7:0]  rdata_q;
    logic        rvalid_q, pstart_q, cstart_q, sstart_q, abort_q;
    logic [15:0] ploc_q, pval_q;

    flag_state_if st ();

    wire        wr_take   = WR_STB & CLK_EN;
    wire        starting  = (start_q != 2'b00);
    // reads in the start window get no answer
    wire        rd_take   = RD_STB & CLK_EN & ~starting;
    wire [7:0]  lo        = WDATA[7:0];
    wire        at_a      = (ADDR == CMD_ADDR_A);
    wire        at_5      = (ADDR == CMD_ADDR_5);
    wire [2:0]  sector    = ADDR[SECT_HI:SECT_LO];
    wire [7:0]  sect_bit  = 8'h01 << sector;
    wire        in_sector = |(mask_q & sect_bit);
    wire        busy      = (mode_q == MODE_PROG) ||
                            (mode_q == MODE_ERASE_WAIT) ||
                            (mode_q == MODE_ERASE) ||
                            (mode_q == MODE_SUSPEND);
    wire        is_reset  = wr_take && (lo == CODE_RESET);
    // a reset code cannot cut a healthy algorithm short, only a hung one
    wire        go_read   = is_reset && (!busy || SEQ_TIME_OVER);
    wire        abort     = is_reset && busy && SEQ_TIME_OVER;
    // word data taken at the given address, odd or even, with no alignment check
    wire        go_prog   = wr_take && (cyc_q == CY_PROG_DATA) && !busy;
    wire        go_chip   = wr_take && (cyc_q == CY_ERASE3) && at_a &&
                            (lo == CODE_CHIP) && !busy;
    wire        go_sect   = wr_take && (cyc_q == CY_ERASE3) &&
                            (lo == CODE_SECTOR) && !busy;
    // more sector codes only while the window is open
    wire        add_sect  = wr_take && (mode_q == MODE_ERASE_WAIT) &&
                            (lo == CODE_SECTOR);
    wire        go_auto   = wr_take && (cyc_q == CY_UNLOCK2) && at_a &&
                            (lo == CODE_AUTOSEL) && !busy;
    wire        go_susp   = wr_take && (mode_q == MODE_ERASE) &&
                            (lo == CODE_SUSPEND);
    wire        go_resume = wr_take && (mode_q == MODE_SUSPEND) &&
                            (lo == CODE_SECTOR);
    wire        alg_done  = SEQ_DONE && ((mode_q == MODE_PROG) ||
                            (mode_q == MODE_ERASE));
    wire        stat_rd   = rd_take && st.is_status;
    wire        tg_step   = stat_rd && (mode_q != MODE_SUSPEND);
    wire        tg2_step  = stat_rd && in_sector && (mode_q != MODE_PROG);
    wire        as_hit    = ((ADDR[7:0] & AS_MASK) == AS_MATCH);

    // unlock cycle tracker
    always_comb begin
        cyc_d = cyc_q;
        if (wr_take) begin
            cyc_d = CY_IDLE;
            case (cyc_q)
                CY_IDLE: begin
                    if (at_a && lo == CODE_AA) cyc_d = CY_UNLOCK1;
                end
                CY_UNLOCK1: begin
                    if (at_5 && lo == CODE_55) cyc_d = CY_UNLOCK2;
                end
                CY_UNLOCK2: begin
                    if (at_a && lo == CODE_PROG) cyc_d = CY_PROG_DATA;
                    if (at_a && lo == CODE_ERASE) cyc_d = CY_ERASE1;
                end
                CY_ERASE1: begin
                    if (at_a && lo == CODE_AA) cyc_d = CY_ERASE2;
                end
                CY_ERASE2: begin
                    if (at_5 && lo == CODE_55) cyc_d = CY_ERASE3;
                end
                default: begin
                    cyc_d = CY_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            MODE_READ, MODE_AUTOSEL: begin
                if (go_prog) mode_d = MODE_PROG;
                else if (go_chip) mode_d = MODE_ERASE;
                else if (go_sect) mode_d = MODE_ERASE_WAIT;
                else if (go_auto) mode_d = MODE_AUTOSEL;
            end
            MODE_ERASE_WAIT: begin
                if (SEQ_ERASE_BEGIN) mode_d = MODE_ERASE;
            end
            MODE_ERASE: begin
                if (go_susp) mode_d = MODE_SUSPEND;
            end
            MODE_SUSPEND: begin
                if (go_resume) mode_d = MODE_ERASE;
            end
            default: begin
                mode_d = mode_q;
            end
        endcase
        // end of algorithm back to read
        if (alg_done) mode_d = MODE_READ;
        if (go_read) mode_d = MODE_READ;
    end

    always_comb begin
        mask_d = mask_q;
        if (go_chip) mask_d = 8'hFF;
        else if (go_sect) mask_d = sect_bit;
        else if (add_sect) mask_d = mask_q | sect_bit;
        if (alg_done || go_read) mask_d = 8'h00;
    end

    assign st.mode        = mode_q;
    assign st.in_sector   = in_sector;
    assign st.toggle      = toggle_q;
    assign st.toggle2     = toggle2_q;
    assign st.time_over   = SEQ_TIME_OVER;
    assign st.last_bit7   = last_bit7_q;
    assign st.sect_prot   = SECT_PROTECTED;
    assign st.autosel_hit = as_hit;
    assign st.array_byte  = ARRAY_DATA[7:0];

    flag_byte_former u_former (
        .st (st)
    );

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            mode_q   <= MODE_READ;
            cyc_q    <= CY_IDLE;
            mask_q   <= 8'h00;
            start_q  <= 2'b00;
        end else if (CLK_EN) begin
            mode_q   <= mode_d;
            cyc_q    <= cyc_d;
            mask_q   <= mask_d;
            start_q  <= (go_prog || go_chip || go_sect) ?
                        START_IGNORE_CYC[1:0] :
                        (starting ? start_q - 2'b01 : 2'b00);
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            toggle_q    <= 1'b0;
            toggle2_q   <= 1'b0;
            last_bit7_q <= 1'b0;
        end else if (CLK_EN) begin
            toggle_q    <= toggle_q ^ tg_step;
            toggle2_q   <= toggle2_q ^ tg2_step;
            if (go_prog) last_bit7_q <= WDATA[7];
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rdata_q  <= RESET_BYTE;
            rvalid_q <= 1'b0;
            pstart_q <= 1'b0;
            cstart_q <= 1'b0;
            sstart_q <= 1'b0;
            abort_q  <= 1'b0;
            ploc_q   <= RESET_WORD;
            pval_q   <= RESET_WORD;
        end else if (CLK_EN) begin
            rvalid_q <= rd_take;
            if (rd_take) rdata_q <= st.read_byte;
            pstart_q <= go_prog;
            cstart_q <= go_chip;
            sstart_q <= go_sect;
            abort_q  <= abort;
            if (go_prog) ploc_q <= ADDR;
            if (go_prog) pval_q <= WDATA;
        end
    end

    assign RDATA              = rdata_q;
    assign RDATA_VALID        = rvalid_q;
    assign PROG_START         = pstart_q;
    assign PROG_LOCATION      = ploc_q;
    assign PROG_VALUE         = pval_q;
    assign CHIP_ERASE_START   = cstart_q;
    assign SECTOR_ERASE_START = sstart_q;
    assign ERASE_SECTORS      = mask_q;
    assign ERASE_SUSPEND      = (mode_q == MODE_SUSPEND);
    assign ALG_ABORT          = abort_q;
    assign ALG_BUSY           = busy;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);

    sequence s_prog_read;
        rd_take && (mode_q == MODE_PROG);
    endsequence
    sequence s_stat_read;
        stat_rd && (mode_q != MODE_SUSPEND);
    endsequence

    AST_PROT_CODE: assert property (
        rd_take && mode_q == MODE_AUTOSEL && as_hit |=>
        RDATA == ($past(SECT_PROTECTED) ? PROT_YES : PROT_NO))
        else $error("protection code wrong");
    AST_RESET_FORM: assert property (
        go_read |=> mode_q == MODE_READ && mask_q == 8'h00)
        else $error("reset code did not return to read");
    AST_ZERO_BITS: assert property (
        stat_rd |=> RDATA_VALID && RDATA[4] == 1'b0 && RDATA[1:0] == 2'b00)
        else $error("unused status bit set");
    AST_DONE_READ: assert property (
        alg_done && CLK_EN |=> mode_q == MODE_READ)
        else $error("no return to read after done");
    AST_PROG_POLL: assert property (
        s_prog_read |=> RDATA[POS_POLL] == ~$past(last_bit7_q) &&
        RDATA[POS_LIMIT] == $past(SEQ_TIME_OVER))
        else $error("program polling bit wrong");
    AST_ERASE_POLL: assert property (
        rd_take && mode_q == MODE_ERASE |=>
        RDATA[POS_POLL] == 1'b0 && RDATA[POS_WINDOW] == 1'b1)
        else $error("erase polling bit wrong");
    AST_SUSP_OTHER: assert property (
        rd_take && mode_q == MODE_SUSPEND && !in_sector |=>
        RDATA == $past(ARRAY_DATA[7:0]))
        else $error("suspend read not true data");
    AST_SUSP_SECT: assert property (
        rd_take && mode_q == MODE_SUSPEND && in_sector |=>
        RDATA[POS_POLL] && RDATA[POS_TOGGLE])
        else $error("suspended sector polling wrong");
    AST_TOGGLE: assert property (
        s_stat_read ##1 s_stat_read |=>
        RDATA[POS_TOGGLE] != $past(RDATA[POS_TOGGLE]))
        else $error("toggle flag did not alternate");
    AST_START_IGNORE: assert property (
        starting && RD_STB |=> !RDATA_VALID)
        else $error("read answered during start");
    AST_WINDOW: assert property (
        rd_take && mode_q == MODE_ERASE_WAIT |=> RDATA[POS_WINDOW] == 1'b0)
        else $error("window flag set while waiting");
endmodule : flash_algorithm_status_flags

// *** tb/flash_array_model.sv ***
// Purpose: array and protection model behind the flag unit
// Assumes: array answers combinationally at the current address
// Notes: one programmed word kept; chip erase blanks the whole array
`timescale 1ns/10ps
module flash_array_model #(
    parameter logic [7:0] PROT_MASK = 8'h5A
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RESETN,
    input  wire logic [15:0] ADDR,
    input  wire logic        PROG_START,
    input  wire logic [15:0] PROG_LOCATION,
    input  wire logic [15:0] PROG_VALUE,
    input  wire logic        CHIP_ERASE_START,
    output logic      [15:0] ARRAY_DATA,
    output logic             SECT_PROTECTED
);
    logic [15:0] loc_q;
    logic [15:0] val_q;
    logic        stored_q;
    logic        erased_q;
    logic        hit;

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            loc_q    <= 16'h0000;
            val_q    <= 16'h0000;
            stored_q <= 1'b0;
            erased_q <= 1'b0;
        end else begin
            if (PROG_START) begin
                loc_q    <= PROG_LOCATION;
                val_q    <= PROG_VALUE;
                stored_q <= 1'b1;
            end
            if (CHIP_ERASE_START) begin
                erased_q <= 1'b1;
            end
        end
    end

    // unwritten places get an address pattern, so stale data shows
    assign hit            = stored_q && (ADDR == loc_q);
    assign ARRAY_DATA     = erased_q ? 16'hFFFF :
                            hit ? val_q : {ADDR[7:0], ADDR[15:8] ^ 8'h96};
    assign SECT_PROTECTED = PROT_MASK[ADDR[15:13]];
endmodule : flash_array_model

// *** tb/flash_algorithm_status_flags_test.sv ***
// Purpose: self-checking bench of the flag unit
// Assumes: host strobes one cycle (two in rd_pair), inputs move 2 ns after the edge
// Notes: sequencer events are pulsed by hand from the scenarios
`timescale 1ns/10ps
`define CHK(what, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("mismatch %s expected %0h seen %0h", what, exp, got); \
        end \
    end

module flash_algorithm_status_flags_test;
    import flash_flags_pkg::*;
    localparam logic [7:0] PROT_MASK = 8'h5A;
    logic        SYS_CLK, RESETN, CLK_EN, WR_STB, RD_STB;
    logic [15:0] ADDR, WDATA, ARRAY_DATA, PROG_LOCATION, PROG_VALUE;
    logic        SECT_PROTECTED, SEQ_DONE, SEQ_TIME_OVER, SEQ_ERASE_BEGIN;
    logic [7:0]  RDATA, ERASE_SECTORS;
    logic        RDATA_VALID, PROG_START, CHIP_ERASE_START;
    logic        SECTOR_ERASE_START, ERASE_SUSPEND, ALG_ABORT, ALG_BUSY;
    int          fail_count;
    int          checks_done;

    flash_algorithm_status_flags dut_u (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
        .CLK_EN(CLK_EN), .WR_STB(WR_STB), .RD_STB(RD_STB), .ADDR(ADDR),
        .WDATA(WDATA), .ARRAY_DATA(ARRAY_DATA),
        .SECT_PROTECTED(SECT_PROTECTED), .SEQ_DONE(SEQ_DONE),
        .SEQ_TIME_OVER(SEQ_TIME_OVER), .SEQ_ERASE_BEGIN(SEQ_ERASE_BEGIN),
        .RDATA(RDATA), .RDATA_VALID(RDATA_VALID), .PROG_START(PROG_START),
        .PROG_LOCATION(PROG_LOCATION), .PROG_VALUE(PROG_VALUE),
        .CHIP_ERASE_START(CHIP_ERASE_START),
        .SECTOR_ERASE_START(SECTOR_ERASE_START),
        .ERASE_SECTORS(ERASE_SECTORS), .ERASE_SUSPEND(ERASE_SUSPEND),
        .ALG_ABORT(ALG_ABORT), .ALG_BUSY(ALG_BUSY));

    flash_array_model #(.PROT_MASK(PROT_MASK)) model_u (.SYS_CLK(SYS_CLK),
        .RESETN(RESETN), .ADDR(ADDR), .PROG_START(PROG_START),
        .PROG_LOCATION(PROG_LOCATION), .PROG_VALUE(PROG_VALUE),
        .CHIP_ERASE_START(CHIP_ERASE_START), .ARRAY_DATA(ARRAY_DATA),
        .SECT_PROTECTED(SECT_PROTECTED));

    function automatic logic [7:0] arr_byte(input logic [15:0] a);
        return a[15:8] ^ 8'h96;
    endfunction : arr_byte

    task finish_test;
        if (fail_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge SYS_CLK);
        #2;
        ADDR   = a;
        WDATA  = d;
        WR_STB = 1'b1;
        @(posedge SYS_CLK);
        #2;
        WR_STB = 1'b0;
    endtask : wr

    // now: strobe at once, right behind a write
    task automatic rd(input logic [15:0] a, input bit now,
                      input logic exp_v, output logic [7:0] d);
        if (!now) begin
            @(posedge SYS_CLK);
            #2;
        end
        ADDR   = a;
        RD_STB = 1'b1;
        @(posedge SYS_CLK);
        #2;
        RD_STB = 1'b0;
        `CHK("read valid", exp_v, RDATA_VALID)
        d = RDATA;
    endtask : rd

    // strobe held over two edges, two answers back to back
    task automatic rd_pair(input logic [15:0] a, output logic [7:0] d0,
                           output logic [7:0] d1);
        @(posedge SYS_CLK);
        #2;
        ADDR   = a;
        RD_STB = 1'b1;
        @(posedge SYS_CLK);
        #2;
        `CHK("pair valid first", 1'b1, RDATA_VALID)
        d0 = RDATA;
        @(posedge SYS_CLK);
        #2;
        RD_STB = 1'b0;
        `CHK("pair valid second", 1'b1, RDATA_VALID)
        d1 = RDATA;
    endtask : rd_pair

    task automatic unlock;
        wr(CMD_ADDR_A, {8'h00, CODE_AA});
        wr(CMD_ADDR_5, {8'h00, CODE_55});
    endtask : unlock

    task automatic seq_pulse(input logic [1:0] sel);
        @(posedge SYS_CLK);
        #2;
        {SEQ_ERASE_BEGIN, SEQ_DONE} = sel;
        @(posedge SYS_CLK);
        #2;
        {SEQ_ERASE_BEGIN, SEQ_DONE} = 2'b00;
    endtask : seq_pulse

    task automatic test_reset_read;
        logic [7:0] d;
        `CHK("rdata at reset", RESET_BYTE, RDATA)
        `CHK("busy at reset", 1'b0, ALG_BUSY)
        rd(16'h4321, 0, 1'b1, d);
        `CHK("array read", arr_byte(16'h4321), d)
        @(posedge SYS_CLK);
        #2;
        CLK_EN = 1'b0;
        rd(16'h4321, 0, 1'b0, d);
        @(posedge SYS_CLK);
        #2;
        CLK_EN = 1'b1;
    endtask : test_reset_read

    task automatic test_autoselect;
        logic [7:0] d;
        unlock();
        wr(CMD_ADDR_A, {8'h00, CODE_AUTOSEL});
        for (int s = 0; s < SECT_N; s++) begin
            rd({s[2:0], 13'h0004}, 0, 1'b1, d);
            `CHK("protect code", PROT_MASK[s] ? PROT_YES : PROT_NO, d)
        end
        rd(16'h2005, 0, 1'b1, d);
        `CHK("query off address", arr_byte(16'h2005), d)
        unlock();
        wr(CMD_ADDR_A, {8'h00, CODE_RESET});
        rd(16'h0004, 0, 1'b1, d);
        `CHK("after long reset", arr_byte(16'h0004), d)
        unlock();
        wr(CMD_ADDR_A, {8'h00, CODE_AUTOSEL});
        wr(16'h1234, {8'h00, CODE_RESET});
        rd(16'h0004, 0, 1'b1, d);
        `CHK("after short reset", arr_byte(16'h0004), d)
    endtask : test_autoselect

    task automatic test_program;
        logic [7:0] a, b;
        unlock();
        wr(CMD_ADDR_A, {8'h00, CODE_PROG});
        wr(16'h2468, 16'h13A5);
        `CHK("program start", 1'b1, PROG_START)
        `CHK("program location", 16'h2468, PROG_LOCATION)
        `CHK("program value", 16'h13A5, PROG_VALUE)
        rd(16'h2468, 1, 1'b0, a);
        rd_pair(16'h2468, a, b);
        `CHK("program status", 8'h04, a & 8'hBF)
        `CHK("program toggle", ~a[6], b[6])
        wr(16'h2468, {8'h00, CODE_RESET});
        `CHK("reset ignored in time", 1'b1, ALG_BUSY)
        SEQ_TIME_OVER = 1'b1;
        rd(16'h2468, 0, 1'b1, a);
        `CHK("failed program", 8'h24, a & 8'hBF)
        SEQ_TIME_OVER = 1'b0;
        seq_pulse(2'b01);
        rd(16'h2468, 0, 1'b1, a);
        `CHK("programmed byte", 8'hA5, a)
        `CHK("program ended", 1'b0, ALG_BUSY)
    endtask : test_program

    task automatic test_sector_erase;
        logic [7:0] a, b, c;
        unlock();
        wr(CMD_ADDR_A, {8'h00, CODE_ERASE});
        unlock();
        wr(16'h6000, {8'h00, CODE_SECTOR});
        `CHK("sector start", 1'b1, SECTOR_ERASE_START)
        `CHK("sector mask", 8'h08, ERASE_SECTORS)
        rd(16'h6010, 0, 1'b1, a);
        `CHK("window status", 8'h00, a & 8'hBB)
        rd(16'h6010, 0, 1'b1, b);
        `CHK("window toggle2", ~a[2], b[2])
        wr(16'hA000, {8'h00, CODE_SECTOR});
        `CHK("added sector", 8'h28, ERASE_SECTORS)
        seq_pulse(2'b10);
        rd(16'hA002, 0, 1'b1, a);
        `CHK("erasing status", 8'h08, a & 8'hBB)
        SEQ_TIME_OVER = 1'b1;
        rd(16'h6010, 0, 1'b1, a);
        rd(16'h0100, 0, 1'b1, b);
        rd(16'h6010, 0, 1'b1, c);
        `CHK("failed erase", 8'h28, a & 8'hBB)
        `CHK("toggle2 other sector", ~a[2], c[2])
        `CHK("erase toggle", ~a[6], b[6])
        SEQ_TIME_OVER = 1'b0;
        wr(16'h0000, {8'h00, CODE_SUSPEND});
        `CHK("suspended", 1'b1, ERASE_SUSPEND)
        rd(16'h6010, 0, 1'b1, a);
        `CHK("suspended sector", 8'hC0, a & 8'hFB)
        rd(16'h0123, 0, 1'b1, b);
        `CHK("other sector data", arr_byte(16'h0123), b)
        wr(16'h6000, {8'h00, CODE_SECTOR});
        `CHK("resumed", 1'b0, ERASE_SUSPEND)
        rd(16'h6010, 0, 1'b1, a);
        `CHK("resumed status", 8'h08, a & 8'hBB)
        SEQ_TIME_OVER = 1'b1;
        wr(16'h0000, {8'h00, CODE_RESET});
        `CHK("abort", 1'b1, ALG_ABORT)
        SEQ_TIME_OVER = 1'b0;
        rd(16'h6010, 0, 1'b1, a);
        `CHK("read after abort", arr_byte(16'h6010), a)
        `CHK("idle after abort", 1'b0, ALG_BUSY)
    endtask : test_sector_erase

    task automatic test_chip_erase;
        logic [7:0] a;
        unlock();
        wr(CMD_ADDR_A, {8'h00, CODE_ERASE});
        unlock();
        wr(CMD_ADDR_A, {8'h00, CODE_CHIP});
        `CHK("chip start", 1'b1, CHIP_ERASE_START)
        rd(16'h4321, 0, 1'b1, a);
        `CHK("chip erase status", 8'h08, a & 8'hBB)
        seq_pulse(2'b01);
        rd(16'h4321, 0, 1'b1, a);
        `CHK("erased byte", 8'hFF, a)
        `CHK("chip erase ended", 1'b0, ALG_BUSY)
    endtask : test_chip_erase

    initial begin
        SYS_CLK = 1'b0;
        forever #12.5 SYS_CLK = ~SYS_CLK;
    end

    // hang guard, far above the run length
    initial begin
        repeat (20000) @(posedge SYS_CLK);
        fail_count++;
        $display("mismatch run length expected end seen hang");
        finish_test();
    end

    initial begin
        fail_count      = 0;
        checks_done     = 0;
        RESETN          = 1'b0;
        CLK_EN          = 1'b1;
        WR_STB          = 1'b0;
        RD_STB          = 1'b0;
        ADDR            = 16'h0000;
        WDATA           = 16'h0000;
        SEQ_DONE        = 1'b0;
        SEQ_TIME_OVER   = 1'b0;
        SEQ_ERASE_BEGIN = 1'b0;
        repeat (3) @(posedge SYS_CLK);
        #2;
        RESETN = 1'b1;
        test_reset_read();
        test_autoselect();
        test_program();
        test_sector_erase();
        test_chip_erase();
        finish_test();
    end
endmodule : flash_algorithm_status_flags_test
